// ==== verilog/trsb_params.svh ====
`ifndef TRSB_PARAMS_SVH
`define TRSB_PARAMS_SVH
// ==========================================
// Widths and reset values
`define TRSB_WORD_W     16
`define TRSB_WORD_RESET 16'h0000
`define TRSB_RELAY_RESET 1'b0
`define TRSB_CONST_LOW  1'b0
`define TRSB_CONST_HIGH 1'b1
// ==========================================
// Direction encoding
`define TRSB_DIR_RIGHT 1'b0
`define TRSB_DIR_LEFT  1'b1
`endif

// ==== verilog/trsb_pkg.sv ====
package trsb_pkg;
  typedef enum logic [1:0] {
    trsb_act_hold,
    trsb_act_load,
    trsb_act_shift
  } trsb_action_t;
endpackage

// ==== verilog/trsb_relay.sv ====
`timescale 1ns/100ps
`include "trsb_params.svh"
module trsb_relay (
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic clk_en_i,
  input  wire logic trig_rise_i,
  input  wire logic set_rise_i,
  input  wire logic set_lvl_i,
  input  wire logic clr_rise_i,
  input  wire logic clr_lvl_i,
  output logic      toggle_relay_out_o
);
  // ==========================================
  // Relay state, clear first then set then toggle
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      toggle_relay_out_o <= `TRSB_RELAY_RESET;
    end else if (clk_en_i) begin
      if (clr_lvl_i || clr_rise_i) begin
        toggle_relay_out_o <= 1'b0;
      end else if (set_lvl_i || set_rise_i) begin
        toggle_relay_out_o <= 1'b1;
      end else if (trig_rise_i) begin
        toggle_relay_out_o <= ~toggle_relay_out_o;
      end
      // Otherwise held after inputs fall
    end
  end
endmodule

// ==== verilog/trsb_shifter.sv ====
`timescale 1ns/100ps
`include "trsb_params.svh"
module trsb_shifter #(
  parameter int WORD_W = `TRSB_WORD_W
) (
  input  wire logic              ref_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              clk_en_i,
  input  wire trsb_pkg::trsb_action_t action_i,
  input  wire logic              dir_i,
  input  wire logic [WORD_W-1:0] load_word_i,
  output logic [WORD_W-1:0]      word_o
);
  // ==========================================
  // Logical shift by one, zero fill
  function automatic logic [WORD_W-1:0] shift_one(input logic [WORD_W-1:0] w, input logic d);
    if (d == `TRSB_DIR_LEFT) begin
      shift_one = {w[WORD_W-2:0], 1'b0};
    end else begin
      shift_one = {1'b0, w[WORD_W-1:1]};
    end
  endfunction

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      word_o <= WORD_W'(`TRSB_WORD_RESET);
    end else if (clk_en_i) begin
      case (action_i)
        trsb_pkg::trsb_act_load:  word_o <= load_word_i;
        trsb_pkg::trsb_act_shift: word_o <= shift_one(word_o, dir_i);
        default:                  word_o <= word_o;
      endcase
    end
  end
endmodule

// ==== verilog/trsb_top.sv ====
`timescale 1ns/100ps
`include "trsb_params.svh"
// Overview of operation
// - Constant-low output is always 0.
// - Constant-high output is always 1.
// - With set and clear idle, trigger rising edge inverts relay output.
// - Set rising edge forces relay output to 1.
// - Set high, clear low: relay stays 1 regardless of trigger.
// - Clear rising edge forces relay output to 0.
// - Clear high keeps relay 0, over set and trigger.
// - Relay holds its state after inputs fall.
// - Shift register holds a 16-bit word; data input is 16 bits.
// - Load captures the data word into register and output.
// - Each step rising edge shifts the word one bit, except repeat edges while load stays high.
// - Direction 0 shifts right, 1 shifts left.
// - Load during shifting discards contents and reloads data word.
// - At most one shift while load stays asserted.
// - Right shifts continue to zero, then stay zero.
// - Write-back option returns each shifted result to the data source.
// - Output shows the stored word after every load or shift.
module trsb_top #(
  parameter int WORD_W = `TRSB_WORD_W
) (
  input  wire logic              ref_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              clk_en_i,
  input  wire logic              trigger_i,
  input  wire logic              set_i,
  input  wire logic              clear_i,
  input  wire logic [WORD_W-1:0] data_word_i,
  input  wire logic              load_i,
  input  wire logic              direction_i,
  input  wire logic              step_i,
  input  wire logic              write_back_en_i,
  output logic                   constant_low_out_o,
  output logic                   constant_high_out_o,
  output logic                   toggle_relay_out_o,
  output logic [WORD_W-1:0]      shifted_word_out_o,
  output logic [WORD_W-1:0]      write_back_word_o,
  output logic                   write_back_valid_o
);
  // ==========================================
  // Constant sources
  assign constant_low_out_o  = `TRSB_CONST_LOW;
  assign constant_high_out_o = `TRSB_CONST_HIGH;

  // ==========================================
  // Previous samples for edge detection
  logic trig_q;
  logic set_q;
  logic clr_q;
  logic load_q;
  logic step_q;

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      trig_q <= 1'b0;
      set_q  <= 1'b0;
      clr_q  <= 1'b0;
      load_q <= 1'b0;
      step_q <= 1'b0;
    end else if (clk_en_i) begin
      trig_q <= trigger_i;
      set_q  <= set_i;
      clr_q  <= clear_i;
      load_q <= load_i;
      step_q <= step_i;
    end
  end

  // ==========================================
  // Toggle relay
  trsb_relay u_relay (
    .ref_clk_i          (ref_clk_i),
    .sys_rst_i          (sys_rst_i),
    .clk_en_i           (clk_en_i),
    .trig_rise_i        (rise(trigger_i, trig_q)),
    .set_rise_i         (rise(set_i, set_q)),
    .set_lvl_i          (set_i),
    .clr_rise_i         (rise(clear_i, clr_q)),
    .clr_lvl_i          (clear_i),
    .toggle_relay_out_o (toggle_relay_out_o)
  );

  // ==========================================
  // Shift control
  // Load is level sensitive so a late data change still reloads; while it
  // stays high only one step edge is honoured.
  logic                   shifted_in_load;
  trsb_pkg::trsb_action_t action;
  logic                   step_rise;

  assign step_rise = rise(step_i, step_q);

  always_comb begin
    action = trsb_pkg::trsb_act_hold;
    if (load_i && step_rise && !shifted_in_load) begin
      action = trsb_pkg::trsb_act_shift;
    end else if (load_i) begin
      action = trsb_pkg::trsb_act_load;
    end else if (step_rise) begin
      action = trsb_pkg::trsb_act_shift;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      shifted_in_load <= 1'b0;
    end else if (clk_en_i) begin
      if (!load_i) begin
        shifted_in_load <= 1'b0;
      end else if (action == trsb_pkg::trsb_act_shift) begin
        shifted_in_load <= 1'b1;
      end
    end
  end

  // Shift during load acts on the stored word, the just-loaded one unless step rises in the same cycle as load
  logic [WORD_W-1:0] held_word;
  logic [WORD_W-1:0] shift_src;

  assign shift_src = held_word;

  trsb_shifter #(
    .WORD_W (WORD_W)
  ) u_shifter (
    .ref_clk_i   (ref_clk_i),
    .sys_rst_i   (sys_rst_i),
    .clk_en_i    (clk_en_i),
    .action_i    (action),
    .dir_i       (direction_i),
    .load_word_i (data_word_i),
    .word_o      (held_word)
  );

  assign shifted_word_out_o = shift_src;

  // ==========================================
  // Write-back toward the data source
  // One-cycle strobe after each shift; the source must take it.
  logic shift_done;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      shift_done <= 1'b0;
    end else if (clk_en_i) begin
      shift_done <= (action == trsb_pkg::trsb_act_shift) && write_back_en_i;
    end
  end

  assign write_back_valid_o = shift_done && clk_en_i;
  assign write_back_word_o  = held_word;
endmodule

// ==== testbench/trsb_monitor.sv ====
`timescale 1ns/100ps
module trsb_monitor #(
  parameter int WORD_W = 16
) (
  input wire logic              ref_clk_i,
  input wire logic              sys_rst_i,
  input wire logic              clk_en_i,
  input wire logic              trigger_i,
  input wire logic              set_i,
  input wire logic              clear_i,
  input wire logic [WORD_W-1:0] data_word_i,
  input wire logic              load_i,
  input wire logic              direction_i,
  input wire logic              step_i,
  input wire logic              write_back_en_i,
  input wire logic              constant_low_out_o,
  input wire logic              constant_high_out_o,
  input wire logic              toggle_relay_out_o,
  input wire logic [WORD_W-1:0] shifted_word_out_o,
  input wire logic              write_back_valid_o
);
  // ==========
  // Edge history valid only after a live edge
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic ok;
  logic live;
  always_ff @(posedge ref_clk_i) ok <= clk_en_i & ~sys_rst_i;
  assign live = clk_en_i & ok;
  // ==========
  // Checks
  a_const_levels: assert property (!constant_low_out_o && constant_high_out_o)
    else $error("constant outputs wrong");
  a_clear_wins: assert property (clk_en_i && clear_i |=> !toggle_relay_out_o)
    else $error("relay not cleared");
  a_set_holds: assert property (clk_en_i && set_i && !clear_i |=> toggle_relay_out_o)
    else $error("relay not set");
  a_trig_flips: assert property (live && $rose(trigger_i) && !set_i && !clear_i
    |=> toggle_relay_out_o != $past(toggle_relay_out_o)) else $error("relay not toggled");
  a_relay_holds: assert property (live && !set_i && !clear_i && !$rose(trigger_i)
    |=> $stable(toggle_relay_out_o)) else $error("relay moved");
  a_step_moves: assert property (live && !load_i && $rose(step_i) |=> shifted_word_out_o ==
    ($past(direction_i) ? $past(shifted_word_out_o) << 1 : $past(shifted_word_out_o) >> 1)) else $error("bad shift");
  a_load_copies: assert property (live && load_i && !$rose(step_i)
    |=> shifted_word_out_o == $past(data_word_i)) else $error("bad load");
  a_wb_pulse: assert property (live && write_back_en_i && !load_i && $rose(step_i)
    |=> write_back_valid_o || !clk_en_i) else $error("no write-back");
  c_toggle: cover property ($rose(toggle_relay_out_o));
  c_wb: cover property (write_back_valid_o);
  c_load_step: cover property (load_i && $rose(step_i));
endmodule
bind trsb_top trsb_monitor #(.WORD_W(WORD_W)) mon_u (.*);

// ==== testbench/trsb_source.sv ====
`timescale 1ns/100ps
// ==========
// Word source feeding the data input; takes write-back results
module trsb_source #(
  parameter int WORD_W = 16
) (
  input  wire logic              ref_clk_i,
  input  wire logic              preset_en_i,
  input  wire logic [WORD_W-1:0] preset_i,
  input  wire logic              wb_valid_i,
  input  wire logic [WORD_W-1:0] wb_word_i,
  output logic      [WORD_W-1:0] word_o
);
  always_ff @(posedge ref_clk_i) begin
    if (preset_en_i) begin
      word_o <= preset_i;
    end else if (wb_valid_i) begin
      word_o <= wb_word_i;
    end
  end
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
module tb;
  localparam int W = 16;
  logic         clk, rst, en, ld, dir, stp, wbe, pre, lo, hi, rl, wv;
  logic [2:0]   rin;
  logic [W-1:0] pw, dw, wo, wbw;
  int           errors, compares;
  trsb_top #(.WORD_W(W)) dut_u (.ref_clk_i(clk), .sys_rst_i(rst), .clk_en_i(en), .trigger_i(rin[2]),
    .set_i(rin[1]), .clear_i(rin[0]), .data_word_i(dw), .load_i(ld), .direction_i(dir), .step_i(stp),
    .write_back_en_i(wbe), .constant_low_out_o(lo), .constant_high_out_o(hi), .toggle_relay_out_o(rl),
    .shifted_word_out_o(wo), .write_back_word_o(wbw), .write_back_valid_o(wv));
  trsb_source #(.WORD_W(W)) src_u (.ref_clk_i(clk), .preset_en_i(pre), .preset_i(pw), .wb_valid_i(wv),
    .wb_word_i(wbw), .word_o(dw));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // ==========
  // Helpers
  task close_out;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [W-1:0] s, e, input string n);
    compares++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask
  task cyc;
    @(negedge clk);
  endtask
  task ld_word(input logic [W-1:0] v);
    pw = v; pre = 1; cyc;
    pre = 0; ld = 1; cyc;
    ld = 0; cyc;
    chk(wo, v, "loaded");
  endtask
  task sh(input logic d, input logic [W-1:0] e);
    dir = d; stp = 1; cyc;
    stp = 0; cyc;
    chk(wo, e, "shifted");
  endtask
  // ==========
  // Scenarios
  task t_relay;
    logic [3:0] seq [13];
    seq = '{4'h0, 4'h9, 4'h1, 4'h8, 4'h0, 4'h5, 4'hD, 4'h2, 4'h2, 4'hE, 4'h6, 4'h0, 4'h9};
    chk(lo, 0, "low");
    chk(hi, 1, "high");
    for (int i = 0; i < 13; i++) begin
      rin = seq[i][3:1]; cyc;
      chk(rl, seq[i][0], "relay");
    end
  endtask
  task t_shift;
    ld_word(16'h8001);
    sh(0, 16'h4000);
    ld_word(16'h8001);
    sh(1, 16'h0002);
    ld_word(16'h0003);
    sh(0, 16'h0001);
    sh(0, 16'h0000);
    sh(0, 16'h0000);
  endtask
  task t_load_hold;
    pw = 16'h0100; pre = 1; dir = 0; cyc;
    pre = 0; ld = 1; cyc;
    stp = 1; cyc;
    chk(wo, 16'h0080, "one shift");
    stp = 0; cyc;
    chk(wo, 16'h0100, "reload");
    stp = 1; cyc;
    chk(wo, 16'h0100, "no second shift");
    stp = 0; ld = 0; cyc;
  endtask
  task t_wb;
    wbe = 1;
    ld_word(16'h0010);
    dir = 0; stp = 1; cyc;
    stp = 0;
    chk(wv, 1, "wb valid");
    cyc;
    chk(wv, 0, "wb pulse end");
    chk(dw, 16'h0008, "source");
    wbe = 0;
    sh(0, 16'h0004);
    chk(dw, 16'h0008, "source kept");
  endtask
  task t_freeze;
    en = 0; rin = 3'b001; stp = 1; cyc;
    chk(rl, 1, "frozen relay");
    chk(wo, 16'h0004, "frozen word");
    en = 1; rin = 3'b000; stp = 0; cyc;
    chk(rl, 1, "relay after freeze");
    chk(wo, 16'h0004, "word after freeze");
  endtask
  task t_reset;
    rin = 0; rst = 1; cyc;
    chk(rl, 0, "relay reset");
    chk(wo, 0, "word reset");
    rst = 0; cyc;
  endtask
  // ==========
  // Main sequence and watchdog, sized well past the run
  initial begin
    rst = 1; en = 1; rin = 0; ld = 0; dir = 0; stp = 0; wbe = 0; pre = 0; pw = 0;
    errors = 0; compares = 0;
    repeat (4) @(posedge clk);
    @(negedge clk) rst = 0;
    t_relay; t_shift; t_load_hold; t_wb; t_freeze; t_reset;
    close_out;
  end
  initial begin
    repeat (1000) @(posedge clk);
    errors++;
    close_out;
  end
endmodule
